/* verification/bias_bus_master.sv */
// Purpose: Byte master model facing the register bank
// Assumes: Framing and slave address are already decoded
// Notes: Waits are bounded; ok low flags a lost answer
`timescale 1ns/10ps
module bias_bus_master (
  // Clock
  input wire logic i_sys_clk,
  // Requests
  output logic o_seq_start,
  output logic o_wr_strobe,
  output logic o_rd_strobe,
  output logic [7:0] o_addr,
  output logic [7:0] o_wr_data,
  // Answers
  input wire logic i_wr_done,
  input wire logic i_wr_ack,
  input wire logic i_rd_valid,
  input wire logic [7:0] i_rd_data
);
  initial begin
    o_seq_start = 1'h0;
    o_wr_strobe = 1'h0;
    o_rd_strobe = 1'h0;
    o_addr = 8'h00;
    o_wr_data = 8'h00;
  end
  task automatic start();
    @(posedge i_sys_clk);
    #1 o_seq_start = 1'h1;
    @(posedge i_sys_clk);
    #1 o_seq_start = 1'h0;
  endtask
  // Strobe is a one-edge pulse; a longer one would repeat the byte
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic ok);
    @(posedge i_sys_clk);
    #1;
    o_addr = a;
    o_wr_data = d;
    o_wr_strobe = w;
    o_rd_strobe = !w;
    @(posedge i_sys_clk);
    #1;
    o_wr_strobe = 1'h0;
    o_rd_strobe = 1'h0;
    ok = 1'h0;
    q = 8'h00;
    repeat (4) begin
      if (!ok && (w ? i_wr_done : i_rd_valid) === 1'h1) begin
        ok = 1'h1;
        q = w ? {7'h00, i_wr_ack} : i_rd_data;
      end else if (!ok) begin
        @(posedge i_sys_clk);
        #1;
      end
    end
    o_addr = ~a;
    o_wr_data = ~d;
  endtask
endmodule

/* verification/lut_bias_control_regs_monitor.sv */
// Purpose: Port checks for the bias register bank
// Assumes: Master waits for each answer before its next byte
// Notes: Latch and tail state are rebuilt from acked writes
`timescale 1ns/10ps
module lut_bias_control_regs_monitor (
  // Clock, reset, recall
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_nv_cr0,
  input wire logic [7:0] i_nv_cr5,
  // Requests
  input wire logic i_seq_start,
  input wire logic i_wr_strobe,
  input wire logic i_rd_strobe,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_conv_valid,
  // Answers
  input wire logic o_wr_done,
  input wire logic o_wr_ack,
  input wire logic o_rd_valid,
  input wire logic [7:0] o_rd_data,
  input wire logic o_nv_wr,
  input wire logic [7:0] o_nv_addr,
  input wire logic [7:0] o_dac_code,
  input wire logic o_current_sink,
  input wire logic [1:0] o_full_scale,
  input wire logic o_recall_done
);
  logic [7:0] addr_reg;
  logic [7:0] data_reg;
  logic wel_reg;
  logic tail_reg;
  logic src_reg;
  logic won;
  logic set_now;
  logic tail_now;
  logic wel_now;
  logic take;
  assign won = o_wr_done && o_wr_ack;
  assign take = i_wr_strobe && o_recall_done && !i_seq_start;
  assign set_now = won && (addr_reg == 8'h80 || addr_reg == 8'h85 ||
    addr_reg == 8'h86);
  assign tail_now = tail_reg || set_now;
  assign wel_now = (won && addr_reg == 8'h86) ?
    (data_reg == 8'h80 || (data_reg != 8'h00 && wel_reg)) : wel_reg;
  // Same-cycle terms keep back-to-back answers in step
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      addr_reg <= 8'h00;
      data_reg <= 8'h00;
      wel_reg <= 1'h0;
      tail_reg <= 1'h0;
      src_reg <= 1'h0;
    end else begin
      if (i_wr_strobe) begin
        addr_reg <= i_addr;
        data_reg <= i_wr_data;
      end
      wel_reg <= wel_now;
      tail_reg <= set_now || (tail_reg && !i_seq_start);
      src_reg <= src_reg || i_conv_valid || o_wr_done
        || (o_recall_done && i_nv_cr5[5:4] != 2'h0);
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  wr_answer_a: assert property (
    i_wr_strobe && o_recall_done |=> o_wr_done) else $error("no answer");
  wr_spurious_a: assert property (
    o_wr_done |-> $past(i_wr_strobe) && $past(o_recall_done))
    else $error("answer without write");
  rd_answer_a: assert property (
    i_rd_strobe |-> ##2 o_rd_valid) else $error("read not answered");
  rsvd_read_a: assert property (i_rd_strobe && (i_addr == 8'h82 ||
    i_addr == 8'h84 || i_addr[7:3] == 5'h11) |-> ##2 o_rd_data == 8'h00)
    else $error("reserved byte not zero");
  latch_block_a: assert property (
    take && !wel_now && i_addr != 8'h86 |=> !o_wr_ack)
    else $error("write acked with latch clear");
  tail_block_a: assert property (
    take && tail_now |=> o_wr_done && !o_wr_ack) else $error("tail acked");
  latch_open_a: assert property (
    take && !tail_now && i_addr == 8'h86 |=> o_wr_ack)
    else $error("latch write refused");
  dac_hold_a: assert property (
    !src_reg |-> o_dac_code == 8'h00) else $error("converter input early");
  recall_value_a: assert property ($rose(o_recall_done) |=>
    o_full_scale == i_nv_cr5[1:0] && o_current_sink == i_nv_cr0[5])
    else $error("recall value wrong");
  nv_copy_a: assert property (
    o_nv_wr |-> won && o_nv_addr == addr_reg) else $error("stray copy");
  cover property (take && tail_now);
  cover property (take && !wel_now && i_addr != 8'h86);
  cover property (o_nv_wr);
endmodule
bind lut_bias_control_regs lut_bias_control_regs_monitor i_monitor (
  .i_sys_clk, .i_reset, .i_nv_cr0, .i_nv_cr5, .i_seq_start, .i_wr_strobe,
  .i_rd_strobe, .i_addr, .i_wr_data, .i_conv_valid, .o_wr_done, .o_wr_ack,
  .o_rd_valid, .o_rd_data, .o_nv_wr, .o_nv_addr, .o_dac_code,
  .o_current_sink, .o_full_scale, .o_recall_done);

/* verification/lut_bias_control_regs_tb.sv */
// Purpose: Self-checking bench for the bias register bank
// Assumes: Recall values stay fixed for the whole run
// Notes: Table data and codes come from a seeded LFSR
`timescale 1ns/10ps
module lut_bias_control_regs_tb;
  logic i_sys_clk, i_reset, i_seq_start, i_wr_strobe, i_rd_strobe;
  logic o_wr_done, o_wr_ack, o_rd_valid, o_nv_wr, i_conv_valid;
  logic o_current_sink, o_recall_done;
  logic [7:0] i_addr, i_wr_data, o_rd_data, o_nv_addr, o_nv_data;
  logic [7:0] i_conv_code, o_dac_code, lfsr_reg, row, val, code;
  logic [1:0] o_full_scale;
  logic [7:0] tbl [64];
  int err_total;
  int checks_done;
  int i;
  lut_bias_control_regs i_lut_bias_control_regs (.i_nv_cr0(8'h20),
    .i_nv_cr1(8'h15), .i_nv_cr3(8'hA5), .i_nv_cr5(8'h02), .i_sys_clk,
    .i_reset, .i_seq_start, .i_wr_strobe, .i_rd_strobe, .i_addr,
    .i_wr_data, .o_wr_done, .o_wr_ack, .o_rd_valid, .o_rd_data, .o_nv_wr,
    .o_nv_addr, .o_nv_data, .i_conv_valid, .i_conv_code, .o_dac_code,
    .o_current_sink, .o_full_scale, .o_recall_done);
  bias_bus_master i_bias_bus_master (.i_sys_clk, .o_seq_start(i_seq_start),
    .o_wr_strobe(i_wr_strobe), .o_rd_strobe(i_rd_strobe), .o_addr(i_addr),
    .o_wr_data(i_wr_data), .i_wr_done(o_wr_done), .i_wr_ack(o_wr_ack),
    .i_rd_valid(o_rd_valid), .i_rd_data(o_rd_data));
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] dac_expect(input logic [7:0] cr5,
    input logic [7:0] rowv, input logic [7:0] direct);
    return cr5[5] ? direct : rowv;
  endfunction
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a,
    input logic [7:0] d, input logic [7:0] exp);
    logic [7:0] q;
    logic ok;
    i_bias_bus_master.xfer(w, a, d, q, ok);
    if (ok !== 1'h1) begin
      err_total++;
      print_verdict();
    end else begin
      check(q, exp);
    end
  endtask
  task automatic conv(input logic [7:0] c);
    @(posedge i_sys_clk);
    #1 i_conv_valid = 1'h1;
    i_conv_code = c;
    @(posedge i_sys_clk);
    #1 i_conv_valid = 1'h0;
  endtask
  initial begin
    i_sys_clk = 1'h0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    i_reset = 1'h1;
    i_conv_valid = 1'h0;
    i_conv_code = 8'h00;
    lfsr_reg = 8'h38;
    err_total = 0;
    checks_done = 0;
    repeat (3) @(posedge i_sys_clk);
    #1 i_reset = 1'h0;
    repeat (2) @(posedge i_sys_clk);
    #1 check(o_dac_code, 8'h00);
    check({5'h00, o_current_sink, o_full_scale}, 8'h06);
    acc(1'h0, 8'h80, 8'h00, 8'h20);
    acc(1'h0, 8'h81, 8'h00, 8'h15);
    acc(1'h0, 8'h83, 8'h00, 8'hA5);
    acc(1'h0, 8'h86, 8'h00, 8'h00);
    acc(1'h1, 8'h85, 8'h03, 8'h00);
    acc(1'h1, 8'h86, 8'h80, 8'h01);
    acc(1'h0, 8'h86, 8'h00, 8'h80);
    acc(1'h1, 8'h83, 8'h5A, 8'h00);
    i_bias_bus_master.start();
    for (i = 0; i < 9; i++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      row = (i == 8) ? 8'h3F : {2'h0, lfsr_reg[5:0]};
      lfsr_reg = lfsr_next(lfsr_reg);
      tbl[row] = lfsr_reg;
      acc(1'h1, 8'h90 + row, lfsr_reg, 8'h01);
      acc(1'h0, 8'h90 + row, 8'h00, tbl[row]);
    end
    acc(1'h1, 8'h81, row, 8'h01);
    acc(1'h1, 8'h83, ~row, 8'h01);
    check(o_nv_addr, 8'h00);
    for (i = 1; i < 4; i++) begin
      val = 8'h11 * i[7:0];
      acc(1'h1, 8'h85, val, 8'h01);
      i_bias_bus_master.start();
      repeat (6) @(posedge i_sys_clk);
      #1 check({6'h00, o_full_scale}, {6'h00, val[1:0]});
      check(o_dac_code, dac_expect(val, tbl[row], ~row));
    end
    acc(1'h1, 8'h80, 8'hC0, 8'h01);
    i_bias_bus_master.start();
    check({7'h00, o_current_sink}, 8'h00);
    code = lfsr_next(lfsr_reg);
    conv(code);
    acc(1'h0, 8'h87, 8'h00, code);
    acc(1'h1, 8'h81, 8'h05, 8'h01);
    check(o_nv_addr, 8'h81);
    check(o_nv_data, 8'h05);
    acc(1'h1, 8'h80, 8'h00, 8'h01);
    i_bias_bus_master.start();
    for (i = 0; i < 4; i++) begin
      conv(code ^ 8'h84);
      acc(1'h0, 8'h87, 8'h00, (i == 3) ? code ^ 8'h84 : code);
    end
    acc(1'h1, 8'h87, 8'h55, 8'h01);
    acc(1'h0, 8'h87, 8'h00, code ^ 8'h84);
    for (i = 0; i < 10; i++) begin
      val = (i < 2) ? 8'h82 + 8'h02 * i[7:0] : 8'h86 + i[7:0];
      acc(1'h0, val, 8'h00, 8'h00);
    end
    row = {2'h0, code[7:2] ^ 6'h21};
    lfsr_reg = lfsr_next(lfsr_reg);
    tbl[row] = lfsr_reg;
    acc(1'h1, 8'h90 + row, lfsr_reg, 8'h01);
    acc(1'h1, 8'h85, 8'h03, 8'h01);
    i_bias_bus_master.start();
    repeat (6) @(posedge i_sys_clk);
    #1 check(o_dac_code, dac_expect(8'h03, tbl[row], 8'h00));
    check({6'h00, o_full_scale}, 8'h03);
    acc(1'h1, 8'h86, 8'h00, 8'h01);
    i_bias_bus_master.start();
    acc(1'h1, 8'h81, 8'h01, 8'h00);
    print_verdict();
  end
endmodule

/* verilog/bias_regs_pkg.sv */
// Purpose: Shared constants for the bias control register bank
// Assumes: Byte wide registers, byte addresses on the access port
// Notes: Bit positions inside the control bytes are fixed here
package bias_regs_pkg;
  localparam int DATA_W = 8;
  localparam int ROW_W = 6;
  localparam int LUT_DEPTH = 64;

  // Register byte addresses
  localparam logic [7:0] ADDR_FILTER_DIR_CFG = 8'h80;
  localparam logic [7:0] ADDR_LUT_ROW_OVERRIDE = 8'h81;
  localparam logic [7:0] ADDR_RESERVED_A = 8'h82;
  localparam logic [7:0] ADDR_DAC_DIRECT = 8'h83;
  localparam logic [7:0] ADDR_RESERVED_B = 8'h84;
  localparam logic [7:0] ADDR_OUTPUT_SOURCE_CFG = 8'h85;
  localparam logic [7:0] ADDR_WRITE_LATCH = 8'h86;
  localparam logic [7:0] ADDR_TEMP_CODE_STATUS = 8'h87;
  localparam logic [7:0] ADDR_RSVD_HI_FIRST = 8'h88;
  localparam logic [7:0] ADDR_RSVD_HI_LAST = 8'h8F;
  localparam logic [7:0] LUT_BASE = 8'h90;
  localparam logic [7:0] LUT_SPAN = 8'h40;

  // Field positions
  localparam int FILTER_BYPASS_BIT = 7;
  localparam int PERSIST_BIT = 6;
  localparam int DIRECTION_BIT = 5;
  localparam int ROW_SEL_BIT = 4;
  localparam int DIRECT_SEL_BIT = 5;
  localparam int FULL_SCALE_LSB = 0;
  localparam int LATCH_BIT = 7;
  localparam int CODE_ROW_LSB = 2;

  // Writable bit masks, reserved bits held at zero
  localparam logic [7:0] MASK_CR0 = 8'hE0;
  localparam logic [7:0] MASK_CR1 = 8'h3F;
  localparam logic [7:0] MASK_CR3 = 8'hFF;
  localparam logic [7:0] MASK_CR5 = 8'h33;

  // Latch command values
  localparam logic [7:0] LATCH_SET_VALUE = 8'h80;
  localparam logic [7:0] LATCH_CLEAR_VALUE = 8'h00;

  // Reset and default values
  localparam logic [7:0] CR0_RESET = 8'h00;
  localparam logic [7:0] CR1_RESET = 8'h00;
  localparam logic [7:0] CR3_RESET = 8'h00;
  localparam logic [7:0] CR5_RESET = 8'h03;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Conversions that must agree, minus one
  localparam logic [1:0] AGREE_LAST = 2'h3;
endpackage

/* verilog/lut_bias_control_regs.sv */
// Purpose: Control and status register bank of the bias current generator
// Assumes: A serial engine delivers decoded byte reads and writes
// Notes: Nonvolatile cells sit outside; recall follows reset release
//
// Operation
// [R01] Control bytes at 80h to 86h, status byte at 87h.
// [R02] Bytes 82h, 84h, 88h to 8Fh are reserved, no function.
// [R03] Power-up clears latch register; registers zero to five recall.
// [R04] Nonvolatile bits persist across power cycles; factory default zero.
// [R05] Master writes reserved bits as zero and ignores them on reads.
// [R06] Bypass updates status each conversion, else after four agreeing.
// [R07] Persistence bit decides whether registers one and three go nonvolatile.
// [R08] Direction bit zero sources current, one sinks it.
// [R09] Row-override select makes override bits address the table.
// [R10] Table byte address is base 90h plus six-bit row.
// [R11] Direct select feeds direct byte to converter, else table row.
// [R12] Two-bit field selects full-scale range; code 00 reserved.
// [R13] Latch must be set first; otherwise writes abort without acknowledge.
// [R14] Writing 80h to 86h sets latch, 00h clears it.
// [R15] Latch change leaves other latch register bits unchanged.
// [R16] Status byte is the temperature code; upper six bits pick row.
// [R17] Sixty-four byte table drives the converter input by default.
// [R18] All controls and table bytes readable and writable by the master.
// [R19] Converter input held at 00h until first valid selection.
// [R20] Data bytes after one written to 80h, 85h, 86h not acknowledged.
// [R21] Writes to the status byte leave it unchanged.
// [R22] Direct select overrides row-override select.
`timescale 1ns/10ps
module lut_bias_control_regs (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Nonvolatile recall values
  input wire logic [7:0] i_nv_cr0,
  input wire logic [7:0] i_nv_cr1,
  input wire logic [7:0] i_nv_cr3,
  input wire logic [7:0] i_nv_cr5,
  // Byte access from the serial engine
  input wire logic i_seq_start,
  input wire logic i_wr_strobe,
  input wire logic i_rd_strobe,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  output logic o_wr_done,
  output logic o_wr_ack,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  // Nonvolatile write request
  output logic o_nv_wr,
  output logic [7:0] o_nv_addr,
  output logic [7:0] o_nv_data,
  // Temperature converter
  input wire logic i_conv_valid,
  input wire logic [7:0] i_conv_code,
  // Current generator controls
  output logic [7:0] o_dac_code,
  output logic o_current_sink,
  output logic [1:0] o_full_scale,
  output logic o_recall_done
);
  logic [7:0] cr0_reg;
  logic [7:0] cr1_reg;
  logic [7:0] cr3_reg;
  logic [7:0] cr5_reg;
  logic [7:0] latch_reg;
  logic [7:0] status_reg;
  logic [7:0] last_code_reg;
  logic [1:0] agree_reg;
  logic status_valid_reg;
  logic tail_block_reg;
  logic rd_pend_reg;
  logic rd_lut_reg;
  logic [7:0] rd_hold_reg;
  logic [7:0] lut_rd_a;
  logic [7:0] lut_rd_b;
  logic dac_enable_reg;

  // Address decode
  wire logic [7:0] lut_offset = i_addr - bias_regs_pkg::LUT_BASE;
  wire logic in_lut = (i_addr >= bias_regs_pkg::LUT_BASE) &&
                      (lut_offset < bias_regs_pkg::LUT_SPAN);
  wire logic [5:0] bus_row =
    lut_offset[bias_regs_pkg::ROW_W-1:0];
  // [R01] Control byte decode
  wire logic sel_cr0 = i_addr == bias_regs_pkg::ADDR_FILTER_DIR_CFG;
  wire logic sel_cr1 = i_addr == bias_regs_pkg::ADDR_LUT_ROW_OVERRIDE;
  wire logic sel_cr3 = i_addr == bias_regs_pkg::ADDR_DAC_DIRECT;
  wire logic sel_cr5 = i_addr == bias_regs_pkg::ADDR_OUTPUT_SOURCE_CFG;
  wire logic sel_latch = i_addr == bias_regs_pkg::ADDR_WRITE_LATCH;
  wire logic sel_status = i_addr == bias_regs_pkg::ADDR_TEMP_CODE_STATUS;

  wire logic write_enable_latch = latch_reg[bias_regs_pkg::LATCH_BIT];
  wire logic adc_filter_bypass = cr0_reg[bias_regs_pkg::FILTER_BYPASS_BIT];
  wire logic persist_cr1_cr3 = cr0_reg[bias_regs_pkg::PERSIST_BIT];
  wire logic current_direction_sel = cr0_reg[bias_regs_pkg::DIRECTION_BIT];
  wire logic lut_row_override_sel = cr5_reg[bias_regs_pkg::ROW_SEL_BIT];
  wire logic dac_direct_sel = cr5_reg[bias_regs_pkg::DIRECT_SEL_BIT];
  wire logic [5:0] lut_row_override =
    cr1_reg[bias_regs_pkg::ROW_W-1:0];
  wire logic [7:0] dac_direct_value = cr3_reg;
  wire logic [1:0] full_scale_sel =
    cr5_reg[bias_regs_pkg::FULL_SCALE_LSB +: 2];
  wire logic [5:0] temp_row =
    status_reg[bias_regs_pkg::CODE_ROW_LSB +: bias_regs_pkg::ROW_W];

  // [R13] Latch gates all writes except the latch byte
  wire logic wr_take = i_wr_strobe && o_recall_done;
  // [R20] Stop acknowledging after a single-byte register
  wire logic wr_accept = wr_take && !tail_block_reg &&
                         (sel_latch || write_enable_latch);
  wire logic tail_set = wr_accept && (sel_cr0 || sel_cr5 || sel_latch);

  // [R07] Nonvolatile copy for registers one and three on persistence
  wire logic nv_hit = wr_accept &&
    (sel_cr0 || sel_cr5 || ((sel_cr1 || sel_cr3) && persist_cr1_cr3));
  // [R18] Table bytes written over the serial port
  wire logic lut_wr = wr_accept && in_lut;

  // [R14] Latch set and clear values, others ignored
  // [R15] Only the latch bit is ever touched
  wire logic latch_set = wr_accept && sel_latch &&
                         (i_wr_data == bias_regs_pkg::LATCH_SET_VALUE);
  wire logic latch_clr = wr_accept && sel_latch &&
                         (i_wr_data == bias_regs_pkg::LATCH_CLEAR_VALUE);
  wire logic [7:0] latch_next = latch_set ? bias_regs_pkg::LATCH_SET_VALUE :
    latch_clr ? bias_regs_pkg::LATCH_CLEAR_VALUE : latch_reg;

  // [R06] Upper six bits compared between conversions
  wire logic [5:0] new_row =
    i_conv_code[bias_regs_pkg::CODE_ROW_LSB +: bias_regs_pkg::ROW_W];
  wire logic [5:0] last_row =
    last_code_reg[bias_regs_pkg::CODE_ROW_LSB +: bias_regs_pkg::ROW_W];
  wire logic code_agrees = new_row == last_row;
  // Saturating count lets steady codes keep reloading the status
  wire logic [1:0] agree_next = !code_agrees ? 2'h0 :
    (agree_reg == bias_regs_pkg::AGREE_LAST) ? agree_reg : agree_reg + 2'h1;
  // [R06] Update on bypass or four agreeing conversions
  wire logic status_load = i_conv_valid && (adc_filter_bypass ||
    (agree_next == bias_regs_pkg::AGREE_LAST));

  // [R02] Reserved bytes and reserved bits read as zero
  // [R16] Status byte returns the temperature code
  wire logic [7:0] reg_rd_data =
    sel_cr0 ? cr0_reg :
    sel_cr1 ? cr1_reg :
    sel_cr3 ? cr3_reg :
    sel_cr5 ? cr5_reg :
    sel_latch ? latch_reg :
    sel_status ? status_reg : bias_regs_pkg::BYTE_ZERO;

  // [R09] Override row replaces the temperature row
  // [R10] Row is the offset from the table base
  wire logic [5:0] dac_row = lut_row_override_sel ? lut_row_override :
                             temp_row;
  // [R19] Valid selection exists once a source is ready
  wire logic dac_enable_next = o_recall_done &&
    (dac_enable_reg || dac_direct_sel || lut_row_override_sel ||
     status_valid_reg);
  // [R11] Direct byte or table row feeds the converter
  // [R22] Direct select wins over row override
  // [R17] Table row is the default converter input
  wire logic [7:0] dac_next = !dac_enable_reg ? bias_regs_pkg::BYTE_ZERO :
    dac_direct_sel ? dac_direct_value : lut_rd_b;

  // Port a serves bus reads, port b the converter path
  // Table output lags the row select by one cycle
  lut_memory u_lut (
    .i_sys_clk(i_sys_clk),
    .i_wr_en(lut_wr),
    .i_wr_row(bus_row),
    .i_wr_data(i_wr_data),
    .i_rd_row_a(bus_row),
    .o_rd_data_a(lut_rd_a),
    .i_rd_row_b(dac_row),
    .o_rd_data_b(lut_rd_b)
  );

  // [R03] Recall one cycle after release, latch stays clear
  // [R04] Nonvolatile values restored from the shadow cells
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_recall_done <= 1'b0;
      cr0_reg <= bias_regs_pkg::CR0_RESET;
      cr1_reg <= bias_regs_pkg::CR1_RESET;
      cr3_reg <= bias_regs_pkg::CR3_RESET;
      cr5_reg <= bias_regs_pkg::CR5_RESET;
    end else if (!o_recall_done) begin
      o_recall_done <= 1'b1;
      cr0_reg <= i_nv_cr0 & bias_regs_pkg::MASK_CR0;
      cr1_reg <= i_nv_cr1 & bias_regs_pkg::MASK_CR1;
      cr3_reg <= i_nv_cr3 & bias_regs_pkg::MASK_CR3;
      cr5_reg <= i_nv_cr5 & bias_regs_pkg::MASK_CR5;
    end else if (wr_accept) begin
      if (sel_cr0) begin
        cr0_reg <= i_wr_data & bias_regs_pkg::MASK_CR0;
      end
      if (sel_cr1) begin
        cr1_reg <= i_wr_data & bias_regs_pkg::MASK_CR1;
      end
      if (sel_cr3) begin
        cr3_reg <= i_wr_data & bias_regs_pkg::MASK_CR3;
      end
      if (sel_cr5) begin
        cr5_reg <= i_wr_data & bias_regs_pkg::MASK_CR5;
      end
    end
  end

  // [R14] Latch register, cleared by reset
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      latch_reg <= bias_regs_pkg::LATCH_RESET;
    end else begin
      latch_reg <= latch_next;
    end
  end

  // Tail block follows a single-byte register write
  // Set wins over a new sequence in the same cycle
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      tail_block_reg <= 1'b0;
    end else if (tail_set) begin
      tail_block_reg <= 1'b1;
    end else if (i_seq_start) begin
      tail_block_reg <= 1'b0;
    end
  end

  // [R21] Status follows conversions only, bus writes never reach it
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      status_reg <= bias_regs_pkg::BYTE_ZERO;
      last_code_reg <= bias_regs_pkg::BYTE_ZERO;
      agree_reg <= 2'h0;
      status_valid_reg <= 1'b0;
    end else if (i_conv_valid) begin
      last_code_reg <= i_conv_code;
      agree_reg <= agree_next;
      if (status_load) begin
        status_reg <= i_conv_code;
        status_valid_reg <= 1'b1;
      end
    end
  end

  // Write answer one cycle after the strobe
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_wr_done <= 1'b0;
      o_wr_ack <= 1'b0;
      o_nv_wr <= 1'b0;
      o_nv_addr <= bias_regs_pkg::BYTE_ZERO;
      o_nv_data <= bias_regs_pkg::BYTE_ZERO;
    end else begin
      o_wr_done <= wr_take;
      o_wr_ack <= wr_accept;
      o_nv_wr <= nv_hit;
      if (nv_hit) begin
        o_nv_addr <= i_addr;
        o_nv_data <= i_wr_data;
      end
    end
  end

  // Two-stage read so table and register data leave from a flop
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      rd_pend_reg <= 1'b0;
      rd_lut_reg <= 1'b0;
      rd_hold_reg <= bias_regs_pkg::BYTE_ZERO;
      o_rd_valid <= 1'b0;
      o_rd_data <= bias_regs_pkg::BYTE_ZERO;
    end else begin
      rd_pend_reg <= i_rd_strobe;
      rd_lut_reg <= in_lut;
      rd_hold_reg <= reg_rd_data;
      o_rd_valid <= rd_pend_reg;
      if (rd_pend_reg) begin
        o_rd_data <= rd_lut_reg ? lut_rd_a : rd_hold_reg;
      end
    end
  end

  // [R08] Direction output, one sinks
  // [R12] Full-scale code passed to the generator
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      dac_enable_reg <= 1'b0;
      o_dac_code <= bias_regs_pkg::BYTE_ZERO;
      o_current_sink <= 1'b0;
      o_full_scale <= bias_regs_pkg::CR5_RESET[1:0];
    end else begin
      dac_enable_reg <= dac_enable_next;
      o_dac_code <= dac_next;
      o_current_sink <= current_direction_sel;
      o_full_scale <= full_scale_sel;
    end
  end
endmodule

/* verilog/lut_memory.sv */
// Purpose: 64 x 8 table storage, one write port, two read ports
// Assumes: Contents are retained outside reset
// Notes: Read data are registered, one cycle latency
`timescale 1ns/10ps
module lut_memory (
  // Clock
  input wire logic i_sys_clk,
  // Write port
  input wire logic i_wr_en,
  input wire logic [bias_regs_pkg::ROW_W-1:0] i_wr_row,
  input wire logic [bias_regs_pkg::DATA_W-1:0] i_wr_data,
  // Bus read port
  input wire logic [bias_regs_pkg::ROW_W-1:0] i_rd_row_a,
  output logic [bias_regs_pkg::DATA_W-1:0] o_rd_data_a,
  // Converter read port
  input wire logic [bias_regs_pkg::ROW_W-1:0] i_rd_row_b,
  output logic [bias_regs_pkg::DATA_W-1:0] o_rd_data_b
);
  logic [bias_regs_pkg::DATA_W-1:0] mem [bias_regs_pkg::LUT_DEPTH];

  always_ff @(posedge i_sys_clk) begin
    if (i_wr_en) begin
      mem[i_wr_row] <= i_wr_data;
    end
    o_rd_data_a <= mem[i_rd_row_a];
    o_rd_data_b <= mem[i_rd_row_b];
  end
endmodule
